// ---- logic/fcps_defines.svh ----
/*
  Constants of the configuration port sequencer: clock rate, pin timing,
  register offsets, field positions and reset values.
  Assumes it is included by its bare name after the package is compiled.
*/
`ifndef FCPS_DEFINES_SVH
`define FCPS_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FCPS_CLK_MHZ          20
`define FCPS_T_CF2ST0_NS      600
`define FCPS_T_STATUS_MIN_US  268
`define FCPS_T_STATUS_MAX_US  1506
`define FCPS_T_CD2UM_MIN_US   175
`define FCPS_T_CD2CU_NS       40
`define FCPS_STARTUP_CYCLES   8576
`define FCPS_DONE_FALLS       2
`define FCPS_POR_CYCLES       2000
`define FCPS_AS_HALF_BASE     8

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FCPS_OFS_CTRL         8'h00
`define FCPS_OFS_LEN          8'h04
`define FCPS_OFS_KEY          8'h08
`define FCPS_OFS_STATUS       8'h0C
`define FCPS_OFS_WORDS        8'h10
`define FCPS_OFS_LAST         8'h14

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define FCPS_CTRL_SCHEME      0
`define FCPS_CTRL_X4          1
`define FCPS_CTRL_RANGE       2
`define FCPS_CTRL_CHAIN       4
`define FCPS_CTRL_USRCLK      5
`define FCPS_CTRL_RATIO       6
`define FCPS_CTRL_WIDTH       10
`define FCPS_CTRL_RST         32'h0000_0100
`define FCPS_LEN_RST          32'h0000_0010
`define FCPS_INITDONE_BIT     0
`define FCPS_AS_READ_CMD      8'h03
`define FCPS_AS_CMD_BITS      4'h8
`define FCPS_RANGE_TOP        2'h3
`define FCPS_WIDTH_X8         2'h0
`define FCPS_WIDTH_X16        2'h1
`define FCPS_WIDTH_X32        2'h2
`define FCPS_HTRANS_NONSEQ    1'b1

`endif

// ---- logic/fcps_pkg.sv ----
/*
  Types of the configuration port sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcps_pkg;

  typedef enum logic [2:0] {
    FCPS_POR,
    FCPS_RESTART,
    FCPS_RELEASE,
    FCPS_LOAD,
    FCPS_FLUSH,
    FCPS_GAP,
    FCPS_INIT,
    FCPS_USER
  } fcps_state_e;

  typedef logic [31:0] fcps_word_t;

endpackage

// ---- logic/fcps_edge_sync.sv ----
/*
  Two-flop synchroniser with a third stage for edge detection.
  Assumes asynchronous inputs; edges are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
module fcps_edge_sync #(
  parameter int Width = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Asynchronous side
  input  wire logic [Width-1:0] asyncIn,
  // Synchronised side
  output logic      [Width-1:0] syncOut,
  output logic      [Width-1:0] rise,
  output logic      [Width-1:0] fall
);

  logic [Width-1:0] meta_reg;
  logic [Width-1:0] sync_reg;
  logic [Width-1:0] last_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign syncOut = sync_reg;
  assign rise    = sync_reg & ~last_reg;
  assign fall    = ~sync_reg & last_reg;

endmodule // fcps_edge_sync

// ---- logic/fcps_sequencer.sv ----
/*
  Configuration port sequencer: restart handshake, parallel passive and
  active serial loading, done flush, initialization and user mode entry,
  with an AHB-Lite register slave.
  Assumes pins arrive asynchronously to clk at 20 MHz.
// How it works
// - Request low in user mode restarts loading
// - Health held low during power-on delay
// - Load-complete low until stream complete
// - Request low drives both outputs low quickly
// - Health low pulse lasts 268 to 1506 us
// - Health released within 1506 us of request
// - Passive word captured on config clock rise
// - Load-complete rises only after whole stream
// - Startup-done driven low once option loaded
// - Oscillator init lasts 175 to 437 us
// - Startup clock enabled late, 8576 cycles
// - Init clock: oscillator or startup clock
// - Active serial clock has four ranges
// - No fastest range in device chains
// - Four-bit mode takes four bits per cycle
// - Command changes after fall, data sampled there
// - Extra ratio cycles decrypt each word
// - Wide parallel ratio is four or eight
*/
`timescale 1ns/1ps
`include "fcps_defines.svh"
module fcps_sequencer import fcps_pkg::*; #(
  parameter int unsigned PorCyc     = `FCPS_POR_CYCLES,
  parameter int unsigned HealthCyc  = `FCPS_T_STATUS_MIN_US * `FCPS_CLK_MHZ,
  parameter int unsigned MaxHealth  = `FCPS_T_STATUS_MAX_US * `FCPS_CLK_MHZ,
  parameter int unsigned StartupCyc = `FCPS_STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Configuration handshake pins
  input  wire logic        cfgRequest_n,
  input  wire logic        healthIn,
  output logic             cfgHealth,
  output logic             loadComplete,
  output logic             startupDone,
  output logic             startupDoneOe,
  // Configuration clock and data
  input  wire logic        config_clock_in,
  output logic             config_clock_out,
  output logic             config_clock_oe,
  input  wire logic [31:0] parallelData,
  input  wire logic [3:0]  serial_flash_data,
  output logic             serial_flash_cmd_out,
  input  wire logic        user_startup_clock
);

  localparam int ReqToLowCyc = `FCPS_T_CF2ST0_NS * `FCPS_CLK_MHZ / 1000;
  localparam int unsigned InitCyc = `FCPS_T_CD2UM_MIN_US * `FCPS_CLK_MHZ;
  localparam int unsigned Cd2CuCyc = (`FCPS_T_CD2CU_NS * `FCPS_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0]  pinSync, pinRise, pinFall;
  logic [35:0] busSync;

  fcps_edge_sync #(.Width(4)) uPins (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({user_startup_clock, healthIn, cfgRequest_n, config_clock_in}),
    .syncOut (pinSync),
    .rise    (pinRise),
    .fall    (pinFall)
  );

  fcps_edge_sync #(.Width(36)) uData (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({serial_flash_data, parallelData}),
    .syncOut (busSync),
    .rise    (),
    .fall    ()
  );

  logic reqSync;
  assign reqSync = pinSync[1];

  // ----------------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------------
  fcps_word_t ctrl_reg, ctrl_next, len_reg, len_next, key_reg, key_next;
  fcps_word_t hrdata_reg, hrdata_next;
  logic       wrPend_reg, wrPend_next;
  logic [7:0] wrAddr_reg, wrAddr_next;
  fcps_state_e state_reg, state_next;
  fcps_word_t wordCount_reg, wordCount_next, lastWord_reg, lastWord_next;
  logic       health_reg, health_next, done_reg, done_next;
  logic       startDone_reg, startDone_next, initDoneEn_reg, initDoneEn_next;

  logic addrPhase;
  assign addrPhase = hsel && hready && (htrans[1] == `FCPS_HTRANS_NONSEQ);

  always_comb begin
    ctrl_next   = ctrl_reg;
    len_next    = len_reg;
    key_next    = key_reg;
    wrPend_next = addrPhase && hwrite;
    wrAddr_next = haddr[7:0];
    hrdata_next = hrdata_reg;
    if (wrPend_reg) begin
      case (wrAddr_reg)
        `FCPS_OFS_CTRL: ctrl_next = hwdata;
        `FCPS_OFS_LEN:  len_next  = hwdata;
        `FCPS_OFS_KEY:  key_next  = hwdata;
        default: ;
      endcase
    end
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        `FCPS_OFS_CTRL:   hrdata_next = ctrl_reg;
        `FCPS_OFS_LEN:    hrdata_next = len_reg;
        `FCPS_OFS_KEY:    hrdata_next = key_reg;
        `FCPS_OFS_STATUS: hrdata_next = {26'h0, startDone_reg, done_reg, health_reg,
                                         state_reg};
        `FCPS_OFS_WORDS:  hrdata_next = wordCount_reg;
        `FCPS_OFS_LAST:   hrdata_next = lastWord_reg;
        default:          hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg   <= `FCPS_CTRL_RST;
      len_reg    <= `FCPS_LEN_RST;
      key_reg    <= 32'h0000_0000;
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg   <= ctrl_next;
      len_reg    <= len_next;
      key_reg    <= key_next;
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // ----------------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------------
  logic       activeSerial, serialX4, chainMode, useUsrClk;
  logic [1:0] parWidth, asRange;
  logic [3:0] ratio;

  function automatic logic [3:0] effRatio(input logic [1:0] w, input logic [3:0] r);
    if (w == `FCPS_WIDTH_X32)
      effRatio = (r > 4'h4) ? 4'h8 : 4'h4;
    else
      effRatio = (r == 4'h0) ? 4'h1 : r;
  endfunction

  function automatic fcps_word_t maskWidth(input logic [1:0] w, input fcps_word_t d);
    case (w)
      `FCPS_WIDTH_X8:  maskWidth = {24'h0, d[7:0]};
      `FCPS_WIDTH_X16: maskWidth = {16'h0, d[15:0]};
      default:         maskWidth = d;
    endcase
  endfunction

  assign activeSerial = ctrl_reg[`FCPS_CTRL_SCHEME];
  assign serialX4     = ctrl_reg[`FCPS_CTRL_X4];
  assign chainMode    = ctrl_reg[`FCPS_CTRL_CHAIN];
  assign useUsrClk    = ctrl_reg[`FCPS_CTRL_USRCLK];
  assign parWidth     = ctrl_reg[`FCPS_CTRL_WIDTH +: 2];
  assign ratio        = effRatio(parWidth, ctrl_reg[`FCPS_CTRL_RATIO +: 4]);
  assign asRange      = (chainMode && ctrl_reg[`FCPS_CTRL_RANGE +: 2] == `FCPS_RANGE_TOP)
                        ? 2'h2 : ctrl_reg[`FCPS_CTRL_RANGE +: 2];

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  fcps_word_t cnt_reg, cnt_next, word_reg, word_next;
  logic [3:0] phase_reg, phase_next;
  logic [7:0] cmd_reg, cmd_next, div_reg, div_next;
  logic       asClk_reg, asClk_next, cmdOut_reg, cmdOut_next;
  logic       cfgRise, cfgFall;

  assign cfgRise = activeSerial ? 1'b0 : pinRise[0];
  assign cfgFall = activeSerial ? (asClk_reg && div_reg == 8'h00) : pinFall[0];

  always_comb begin
    fcps_word_t w;
    logic       fin;
    w               = word_reg;
    fin             = 1'b0;
    state_next      = state_reg;
    cnt_next        = cnt_reg + 32'h1;
    word_next       = word_reg;
    phase_next      = phase_reg;
    cmd_next        = cmd_reg;
    div_next        = div_reg;
    asClk_next      = asClk_reg;
    cmdOut_next     = cmdOut_reg;
    wordCount_next  = wordCount_reg;
    lastWord_next   = lastWord_reg;
    health_next     = health_reg;
    done_next       = done_reg;
    startDone_next  = startDone_reg;
    initDoneEn_next = initDoneEn_reg;
    // Device-made serial clock, half period halves per range
    if (activeSerial && (state_reg == FCPS_LOAD || state_reg == FCPS_FLUSH)) begin
      if (div_reg == 8'h00) begin
        div_next   = 8'(`FCPS_AS_HALF_BASE >> asRange) - 8'h1;
        asClk_next = !asClk_reg;
      end else begin
        div_next = div_reg - 8'h1;
      end
    end else begin
      asClk_next = 1'b0;
      div_next   = 8'h00;
    end
    case (state_reg)
      FCPS_POR: begin
        health_next = 1'b0;
        done_next   = 1'b0;
        if (cnt_reg >= PorCyc) begin
          state_next  = FCPS_LOAD;
          health_next = 1'b1;
          cnt_next    = '0;
        end
      end
      FCPS_RESTART: begin
        cnt_next = '0;
        if (reqSync)
          state_next = FCPS_RELEASE;
      end
      FCPS_RELEASE: begin
        if (cnt_reg >= HealthCyc - 1)
          health_next = 1'b1;
        if (health_reg && pinSync[2]) begin
          state_next = FCPS_LOAD;
          cnt_next   = '0;
        end
      end
      FCPS_LOAD: begin
        cnt_next = cnt_reg;
        if (!activeSerial && cfgRise) begin
          w = (phase_reg == 4'h0) ? maskWidth(parWidth, busSync[31:0])
              : ({word_reg[30:0], word_reg[31]} ^ key_reg);
          word_next = w;
          if (phase_reg == ratio - 4'h1) begin
            fin        = 1'b1;
            phase_next = 4'h0;
          end else begin
            phase_next = phase_reg + 4'h1;
          end
        end
        if (activeSerial && cfgFall) begin
          if (phase_reg < `FCPS_AS_CMD_BITS) begin
            cmdOut_next = cmd_reg[7];
            cmd_next    = {cmd_reg[6:0], 1'b0};
            phase_next  = phase_reg + 4'h1;
          end else begin
            w = serialX4 ? {word_reg[27:0], busSync[35:32]}
                : {word_reg[30:0], busSync[32]};
            word_next = w;
            cnt_next  = cnt_reg + (serialX4 ? 32'h4 : 32'h1);
            if (cnt_next == 32'd32) begin
              fin      = 1'b1;
              cnt_next = '0;
            end
          end
        end
        if (fin) begin
          lastWord_next  = w;
          wordCount_next = wordCount_reg + 32'h1;
          if (wordCount_reg == 32'h0)
            initDoneEn_next = w[`FCPS_INITDONE_BIT];
          if (wordCount_next == len_reg) begin
            done_next  = 1'b1;
            state_next = FCPS_FLUSH;
            cnt_next   = '0;
          end
        end
      end
      FCPS_FLUSH: begin
        cnt_next = cnt_reg;
        if (cfgFall)
          cnt_next = cnt_reg + 32'h1;
        if (cnt_next == `FCPS_DONE_FALLS) begin
          state_next = useUsrClk ? FCPS_GAP : FCPS_INIT;
          cnt_next   = '0;
        end
      end
      FCPS_GAP: begin
        if (cnt_reg >= Cd2CuCyc - 1) begin
          state_next = FCPS_INIT;
          cnt_next   = '0;
        end
      end
      FCPS_INIT: begin
        if (useUsrClk)
          cnt_next = pinRise[3] ? cnt_reg + 32'h1 : cnt_reg;
        if ((useUsrClk && cnt_next >= StartupCyc) || (!useUsrClk && cnt_next >= InitCyc)) begin
          state_next     = FCPS_USER;
          startDone_next = 1'b1;
        end
      end
      FCPS_USER: cnt_next = '0;
      default:   state_next = FCPS_POR;
    endcase
    if (state_next == FCPS_LOAD && state_reg != FCPS_LOAD) begin
      word_next      = '0;
      phase_next     = 4'h0;
      cmd_next       = `FCPS_AS_READ_CMD;
      wordCount_next = '0;
      startDone_next = 1'b0;
    end
    if (!reqSync && state_reg != FCPS_POR) begin
      state_next      = FCPS_RESTART;
      health_next     = 1'b0;
      done_next       = 1'b0;
      startDone_next  = 1'b0;
      initDoneEn_next = 1'b0;
      cnt_next        = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= FCPS_POR;
      cnt_reg        <= '0;
      word_reg       <= '0;
      phase_reg      <= 4'h0;
      cmd_reg        <= `FCPS_AS_READ_CMD;
      div_reg        <= 8'h00;
      asClk_reg      <= 1'b0;
      cmdOut_reg     <= 1'b0;
      wordCount_reg  <= '0;
      lastWord_reg   <= '0;
      health_reg     <= 1'b0;
      done_reg       <= 1'b0;
      startDone_reg  <= 1'b0;
      initDoneEn_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      word_reg       <= word_next;
      phase_reg      <= phase_next;
      cmd_reg        <= cmd_next;
      div_reg        <= div_next;
      asClk_reg      <= asClk_next;
      cmdOut_reg     <= cmdOut_next;
      wordCount_reg  <= wordCount_next;
      lastWord_reg   <= lastWord_next;
      health_reg     <= health_next;
      done_reg       <= done_next;
      startDone_reg  <= startDone_next;
      initDoneEn_reg <= initDoneEn_next;
    end
  end

  assign cfgHealth            = health_reg;
  assign loadComplete         = done_reg;
  assign startupDone          = startDone_reg;
  assign startupDoneOe        = initDoneEn_reg;
  assign config_clock_out     = asClk_reg;
  assign config_clock_oe      = activeSerial;
  assign serial_flash_cmd_out = cmdOut_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Cycles with health low since the request line was released
  fcps_word_t lowCnt_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      lowCnt_reg <= '0;
    else
      lowCnt_reg <= (health_reg || state_reg == FCPS_RESTART) ? '0 : lowCnt_reg + 32'h1;
  end

  sequence s_reqFall;
    $fell(reqSync) && state_reg != FCPS_POR;
  endsequence

  property p_reqHealth;
    @(posedge clk) disable iff (!reset_n) s_reqFall |-> ##[1:ReqToLowCyc] !cfgHealth;
  endproperty
  a_reqHealth: assert property (p_reqHealth) else $error("health not low after request");

  property p_reqDone;
    @(posedge clk) disable iff (!reset_n) s_reqFall |-> ##1 !loadComplete [*2];
  endproperty
  a_reqDone: assert property (p_reqDone) else $error("done not low after request");

  property p_porHealth;
    @(posedge clk) disable iff (!reset_n) state_reg == FCPS_POR |-> !cfgHealth && !loadComplete;
  endproperty
  a_porHealth: assert property (p_porHealth) else $error("health high during power-on");

  property p_loadLow;
    @(posedge clk) disable iff (!reset_n)
      state_reg == FCPS_LOAD && wordCount_reg != len_reg |-> !loadComplete;
  endproperty
  a_loadLow: assert property (p_loadLow) else $error("done high while loading");

  property p_healthPulse;
    @(posedge clk) disable iff (!reset_n) $rose(cfgHealth) && $past(state_reg) == FCPS_RELEASE
      |-> lowCnt_reg >= HealthCyc && lowCnt_reg <= MaxHealth;
  endproperty
  a_healthPulse: assert property (p_healthPulse) else $error("health pulse length wrong");

  property p_healthMax;
    @(posedge clk) disable iff (!reset_n) state_reg == FCPS_RELEASE |-> lowCnt_reg <= MaxHealth;
  endproperty
  a_healthMax: assert property (p_healthMax) else $error("health held low too long");

  property p_doneWhole;
    @(posedge clk) disable iff (!reset_n) $rose(loadComplete) |-> wordCount_reg == len_reg;
  endproperty
  a_doneWhole: assert property (p_doneWhole) else $error("done before whole stream");

  property p_initLow;
    @(posedge clk) disable iff (!reset_n)
      startupDoneOe && state_reg != FCPS_USER |-> !startupDone;
  endproperty
  a_initLow: assert property (p_initLow) else $error("startup done high early");

  property p_userHigh;
    @(posedge clk) disable iff (!reset_n)
      $past(state_reg) == FCPS_INIT && state_reg == FCPS_USER |-> startupDone;
  endproperty
  a_userHigh: assert property (p_userHigh) else $error("startup done not high in user");

  property p_chain;
    @(posedge clk) disable iff (!reset_n)
      chainMode && $changed(config_clock_out) |=> $stable(config_clock_out) || !reqSync;
  endproperty
  a_chain: assert property (p_chain) else $error("fastest range used in chain");

endmodule // fcps_sequencer

// ---- bench/fcps_host_model.sv ----
/*
  Host model: parallel passive clock, data and the pulled-up health line.
  Assumes the clock stands low between words.
*/
`timescale 1ns/1ps
module fcps_host_model (
  // Host-driven pins
  output logic        cfgClk,
  output logic [31:0] cfgData,
  output logic        healthLine,
  // Device health output
  input  wire logic   devHealth,
  // Serial flash side
  input  wire logic   asClk,
  input  wire logic   cmdIn,
  input  wire logic [31:0] flashWord,
  output logic      [3:0]  flashData
);
  // Pull-up only, the host never holds the line low
  assign healthLine = devHealth;

  initial begin
    cfgClk = 1'b0;
    cfgData = 32'h0;
    flashData = 4'h0;
  end

  // Serial flash: one nibble of flashWord after each fall, MSB first,
  // aligned so that the first data fall after the command sees nibble 0
  int         nRise = 0;
  logic [7:0] cmdSeen = 8'h00;

  always @(posedge asClk) begin
    nRise <= nRise + 1;
    if (nRise >= 1 && nRise <= 8)
      cmdSeen <= {cmdSeen[6:0], cmdIn};
  end

  always @(negedge asClk)
    flashData <= flashWord[31 - 4 * (nRise % 8) -: 4];

  task automatic pulse();
    cfgClk = 1'b1;
    #200;
    cfgClk = 1'b0;
    #200;
  endtask

  // Word stands before the first rise and across all n rises
  task automatic sendWord(input logic [31:0] w, input int n);
    cfgData = w;
    #200;
    repeat (n) pulse();
    cfgData = ~w;
  endtask

  task automatic flush();
    repeat (2) pulse();
  endtask
endmodule // fcps_host_model

// ---- bench/test_fpga_config_port_sequencer.sv ----
/*
  Self-checking bench of the configuration port sequencer.
  Assumes the package, design files and host model are compiled first.
*/
`timescale 1ns/1ps
module test_fpga_config_port_sequencer import fcps_pkg::*;;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  fcps_word_t  hwdata = 32'h0;
  logic        cfgRequest_n = 1'b1;
  logic        hready, hreadyout, hresp, healthIn, cfgHealth, loadComplete;
  logic        startupDone, startupDoneOe, cfgClk, cmdOut, ccOut, ccOe;
  logic [31:0] hrdata, pData;
  logic [3:0]  flashData;
  logic        usrClk = 1'b0;
  fcps_word_t  pat = 32'h0;
  fcps_word_t  seed = 32'd96;
  int          n_errors = 0;
  int          compares = 0;

  always #25 clk = ~clk;
  always @(posedge clk) usrClk <= ~usrClk;
  assign hready = hreadyout;

  fcps_sequencer #(.PorCyc(10), .HealthCyc(20), .MaxHealth(100), .StartupCyc(8))
    u_fcps_sequencer (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfgRequest_n(cfgRequest_n),
    .healthIn(healthIn), .cfgHealth(cfgHealth), .loadComplete(loadComplete),
    .startupDone(startupDone), .startupDoneOe(startupDoneOe),
    .config_clock_in(cfgClk), .config_clock_out(ccOut), .config_clock_oe(ccOe),
    .parallelData(pData), .serial_flash_data(flashData), .serial_flash_cmd_out(cmdOut),
    .user_startup_clock(usrClk));

  fcps_host_model u_fcps_host_model (.cfgClk(cfgClk), .cfgData(pData),
    .healthLine(healthIn), .devHealth(cfgHealth), .asClk(ccOut), .cmdIn(cmdOut),
    .flashWord(pat), .flashData(flashData));

  function automatic fcps_word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Capture then rotate-xor once per extra clock of the ratio
  function automatic fcps_word_t unscramble(fcps_word_t w, fcps_word_t k, int n);
    for (int i = 1; i < n; i++) w = {w[30:0], w[31]} ^ k;
    return w;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic flag(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Single word transfer; waits for hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input fcps_word_t wd,
                     output fcps_word_t rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    flag(hresp, 1'b0);
  endtask

  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    fcps_word_t r, key, w;
    int k;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    flag(cfgHealth, 1'b0);
    flag(loadComplete, 1'b0);
    bus(1'b0, 32'h0, 32'h0, r);
    check(r, 32'h100);
    bus(1'b0, 32'h4, 32'h0, r);
    check(r, 32'h10);
    bus(1'b0, 32'h40, 32'h0, r);
    check(r, 32'h0);
    k = 0;
    while (cfgHealth !== 1'b1 && k < 200) begin @(posedge clk); k++; end
    flag(cfgHealth, 1'b1);
    repeat (40) @(posedge clk);
    key = rnd();
    pat = rnd();
    bus(1'b1, 32'h8, key, r);
    bus(1'b1, 32'h0, 32'h900, r);
    bus(1'b1, 32'h4, 32'h3, r);
    for (int i = 0; i < 3; i++) begin
      w = rnd();
      if (i == 0) w[0] = 1'b1;
      u_fcps_host_model.sendWord(w, 4);
      repeat (4) @(posedge clk);
      flag(loadComplete, i == 2);
      bus(1'b0, 32'h14, 32'h0, r);
      check(r, unscramble(w, key, 4));
    end
    flag(startupDoneOe, 1'b1);
    flag(startupDone, 1'b0);
    $display("Load test done");
    u_fcps_host_model.flush();
    k = 16;
    while (startupDone !== 1'b1 && k < 9000) begin @(posedge clk); k++; end
    flag(k >= 3500 && k <= 8740, 1'b1);
    bus(1'b0, 32'hC, 32'h0, r);
    check(r & 32'h3F, 32'h3F);
    $display("Init test done");
    cfgRequest_n <= 1'b0;
    repeat (12) @(posedge clk);
    flag(cfgHealth, 1'b0);
    flag(loadComplete, 1'b0);
    repeat (24) @(posedge clk);
    // Serial x4, fastest range in a chain, user startup clock, two words
    bus(1'b1, 32'h4, 32'h2, r);
    bus(1'b1, 32'h0, 32'h3F, r);
    cfgRequest_n <= 1'b1;
    k = 0;
    while (cfgHealth !== 1'b1 && k < 100) begin @(posedge clk); k++; end
    flag(k >= 19 && k < 100, 1'b1);
    // Load starts once the sensed health line is back high
    repeat (4) @(posedge clk);
    bus(1'b0, 32'hC, 32'h0, r);
    check(r & 32'h7, 32'h3);
    $display("Restart test done");
    k = 0;
    while (startupDone !== 1'b1 && k < 400) begin @(posedge clk); k++; end
    flag(startupDone, 1'b1);
    flag(ccOe, 1'b1);
    bus(1'b0, 32'h14, 32'h0, r);
    check(r, pat);
    bus(1'b0, 32'h10, 32'h0, r);
    check(r, 32'h2);
    check({24'h0, u_fcps_host_model.cmdSeen}, 32'h3);
    $display("Serial test done");
    report_and_stop();
  end
endmodule // test_fpga_config_port_sequencer
